// File: byte_fifo.sv
// Byte FIFO with multi-byte push and pop per cycle
module byte_fifo (
  input wire logic clk_in,
  input wire logic rst_n_in,
  fifo_if.storage port
);
  import nand_fifo_pkg::*;

  logic [7:0] mem [FIFO_DEPTH];
  logic [7:0] next_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [LEVEL_W-1:0] level, next_level;

  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_level = level;
    for (int i = 0; i < WORD_BYTES; i++) begin
      // Bytes past the access width read as zero
      if (4'(i) < port.pop_n) begin
        port.pop_data[8*i +: 8] = mem[PTR_W'(rd_ptr + PTR_W'(i))];
      end else begin
        port.pop_data[8*i +: 8] = 8'h00;
      end
    end
    if (port.flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_level = '0;
    end else begin
      if (port.push) begin
        for (int i = 0; i < WORD_BYTES; i++) begin
          if (4'(i) < port.push_n) begin
            next_mem[PTR_W'(wr_ptr + PTR_W'(i))] = port.push_data[8*i +: 8];
          end
        end
        next_wr_ptr = PTR_W'(wr_ptr + PTR_W'(port.push_n));
      end
      if (port.pop) begin
        next_rd_ptr = PTR_W'(rd_ptr + PTR_W'(port.pop_n));
      end
      next_level = LEVEL_W'(level + (port.push ? LEVEL_W'(port.push_n) : 8'h00)
        - (port.pop ? LEVEL_W'(port.pop_n) : 8'h00));
    end
    port.level = level;
    port.level_next = next_level;
  end

  always_ff @(posedge clk_in) begin
    mem <= next_mem;
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
  end

  property p_level_bound;
    @(posedge clk_in) disable iff (!rst_n_in)
    port.push |-> (9'(level) + 9'(port.push_n) <= 9'(FIFO_DEPTH)) && (level <= 8'h80);
  endproperty
  a_level_bound: assert property (p_level_bound)
    else $error("byte fifo overfilled");
endmodule // byte_fifo

// File: fifo_if.sv
// Connection between the control logic and one byte FIFO
interface fifo_if;
  logic flush;
  logic push;
  logic [3:0] push_n;
  logic [63:0] push_data;
  logic pop;
  logic [3:0] pop_n;
  logic [63:0] pop_data;
  logic [7:0] level;
  logic [7:0] level_next;
  modport producer (output flush, push, push_n, push_data, pop, pop_n,
    input pop_data, level, level_next);
  modport storage (input flush, push, push_n, push_data, pop, pop_n,
    output pop_data, level, level_next);
endinterface

// File: flash_side_model.sv
// Flash side model: receive byte source and stalling transmit byte sink
module flash_side_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] rx_todo_in,
  input wire logic sink_en_in,
  input wire logic rx_byte_ready_in,
  output logic rx_byte_valid_out,
  output logic [7:0] rx_byte_out,
  input wire logic tx_byte_valid_in,
  input wire logic [7:0] tx_byte_in,
  output logic tx_byte_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sent;
  logic [15:0] cnt;
  logic [7:0] sent_q[$];
  logic [7:0] got_q[$];
  int seed = 29212;
  int r;
  always @(posedge clk_in) begin
    r = $random(seed);
    cnt = sent + 16'(rx_byte_valid_out && rx_byte_ready_in);
    if (!rst_n_in) begin
      sent <= 16'h0;
      rx_byte_valid_out <= 1'b0;
      tx_byte_ready_out <= 1'b0;
      rx_byte_out <= 8'h5a;
    end else begin
      if (rx_byte_valid_out && rx_byte_ready_in) sent_q.push_back(rx_byte_out);
      sent <= cnt;
      rx_byte_valid_out <= cnt < rx_todo_in;
      // Idle line toggles so no stale byte looks valid
      if (cnt >= rx_todo_in) rx_byte_out <= ~rx_byte_out;
      else if (cnt != sent || !rx_byte_valid_out) rx_byte_out <= r[15:8];
      if (tx_byte_valid_in && tx_byte_ready_out) got_q.push_back(tx_byte_in);
      tx_byte_ready_out <= sink_en_in && r[0];
    end
  end
endmodule // flash_side_model

// File: nand_async_fifo_thresholds.sv
// NAND data FIFO pair with width control, level flags and register slave
// How it works
// - Receive width field 21:20 sets internal read size: 00=8, 01=16, 11=64.
// - Transmit width field 19:18 sets internal write size: 8, 16, 32, 64.
// - Each FIFO packs or unpacks 8/16/32/64-bit words to the flash byte stream.
// - Receive level flag and interrupt rise when stored bytes exceed bits 15:8.
// - Transmit space flag and interrupt rise when free bytes reach bits 7:0.
// - Writing one to status bit 31 flushes receive, bit 30 flushes transmit.
// - Status reports receive stored bytes in 15:8, transmit free bytes in 7:0.
//
// The Avalon-MM slave port was decided locally.
module nand_async_fifo_thresholds (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [nand_fifo_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic rx_byte_valid_in,
  input wire logic [7:0] rx_byte_in,
  output logic rx_byte_ready_out,
  output logic tx_byte_valid_out,
  output logic [7:0] tx_byte_out,
  input wire logic tx_byte_ready_in,
  input wire logic rx_word_rd_in,
  output logic [nand_fifo_pkg::WORD_BITS-1:0] rx_word_out,
  output logic rx_word_valid_out,
  output logic rx_word_avail_out,
  input wire logic tx_word_wr_in,
  input wire logic [nand_fifo_pkg::WORD_BITS-1:0] tx_word_in,
  output logic tx_word_room_out,
  output logic rx_level_flag_out,
  output logic tx_space_flag_out,
  output logic irq_out
);
  import nand_fifo_pkg::*;

  fifo_if rx_if();
  fifo_if tx_if();

  byte_fifo u_rx_fifo (.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .port(rx_if.storage));
  byte_fifo u_tx_fifo (.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .port(tx_if.storage));

  // ==========================================================================
  // State
  logic [31:0] cfg, next_cfg;
  logic [IRQ_W-1:0] irq_status, next_irq_status, irq_mask, next_irq_mask;
  logic [31:0] next_readdata;
  logic next_waitrequest, next_irq;
  logic [WORD_BITS-1:0] next_rx_word;
  logic next_rx_word_valid, next_rx_avail, next_tx_room, next_rx_ready;
  logic next_tx_valid, next_rx_flag, next_tx_flag;
  logic [7:0] next_tx_byte;
  logic [3:0] rx_n, tx_n;
  logic [LEVEL_W-1:0] tx_free, tx_free_next;
  logic write_take;
  logic [IRQ_W-1:0] irq_event, irq_clear;

  // ==========================================================================
  // Register read mux
  function automatic logic [31:0] reg_read(input logic [7:0] addr, input logic [31:0] c,
      input logic [7:0] rx_level, input logic [7:0] free, input logic [1:0] st,
      input logic [1:0] msk);
    unique case (addr)
      FIFO_STATUS_OFS: reg_read = {16'h0000, rx_level, free};
      FIFO_CFG_OFS: reg_read = c;
      IRQ_STATUS_OFS: reg_read = {30'h0, st};
      IRQ_MASK_OFS: reg_read = {30'h0, msk};
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb begin
    rx_n = size_bytes(cfg[RX_SIZE_LSB +: 2]);
    tx_n = size_bytes(cfg[TX_SIZE_LSB +: 2]);
    tx_free = LEVEL_W'(FIFO_DEPTH) - tx_if.level;
    tx_free_next = LEVEL_W'(FIFO_DEPTH) - tx_if.level_next;
    write_take = avs_write_in && !avs_waitrequest_out;

    rx_if.flush = write_take && avs_address_in == FIFO_STATUS_OFS && avs_byteenable_in[3]
      && avs_writedata_in[RX_FLUSH_BIT];
    tx_if.flush = write_take && avs_address_in == FIFO_STATUS_OFS && avs_byteenable_in[3]
      && avs_writedata_in[TX_FLUSH_BIT];

    // Flash side fills receive, internal side drains it in words
    rx_if.push = rx_byte_valid_in && rx_byte_ready_out && !rx_if.flush;
    rx_if.push_n = 4'h1;
    rx_if.push_data = {56'h0, rx_byte_in};
    rx_if.pop = rx_word_rd_in && (rx_if.level >= {4'h0, rx_n}) && !rx_if.flush;
    rx_if.pop_n = rx_n;

    // Internal side fills transmit in words, flash side drains bytes
    tx_if.push = tx_word_wr_in && (tx_free >= {4'h0, tx_n}) && !tx_if.flush;
    tx_if.push_n = tx_n;
    tx_if.push_data = tx_word_in;
    tx_if.pop = (tx_if.level != 8'h00) && (!tx_byte_valid_out || tx_byte_ready_in)
      && !tx_if.flush;
    tx_if.pop_n = 4'h1;

    next_rx_word = rx_if.pop ? rx_if.pop_data : rx_word_out;
    next_rx_word_valid = rx_if.pop;
    next_rx_ready = rx_if.level_next < LEVEL_W'(FIFO_DEPTH);
    next_rx_avail = rx_if.level_next >= {4'h0, rx_n};
    next_tx_room = tx_free_next >= {4'h0, tx_n};
    next_tx_byte = tx_if.pop ? tx_if.pop_data[7:0] : tx_byte_out;
    if (tx_if.flush) begin
      next_tx_valid = 1'b0;
    end else if (tx_if.pop) begin
      next_tx_valid = 1'b1;
    end else if (tx_byte_ready_in) begin
      next_tx_valid = 1'b0;
    end else begin
      next_tx_valid = tx_byte_valid_out;
    end

    // Flags follow the threshold; the interrupt event is their rise
    next_rx_flag = rx_if.level_next > cfg[RX_THR_LSB +: 8];
    // Drain frees one byte per cycle, so the rise lands on equality
    next_tx_flag = tx_free_next >= cfg[TX_THR_LSB +: 8];
    irq_event = '0;
    irq_event[IRQ_RX_LEVEL] = next_rx_flag && !rx_level_flag_out;
    irq_event[IRQ_TX_SPACE] = next_tx_flag && !tx_space_flag_out;

    // Bus writes take effect at the edge that sees waitrequest low
    next_cfg = cfg;
    next_irq_mask = irq_mask;
    irq_clear = '0;
    if (write_take) begin
      unique case (avs_address_in)
        FIFO_CFG_OFS: begin
          for (int b = 0; b < 4; b++) begin
            if (avs_byteenable_in[b]) begin
              next_cfg[8*b +: 8] = avs_writedata_in[8*b +: 8];
            end
          end
          next_cfg = next_cfg & FIFO_CFG_MASK;
        end
        IRQ_STATUS_OFS: begin
          if (avs_byteenable_in[0]) begin
            irq_clear = avs_writedata_in[IRQ_W-1:0];
          end
        end
        IRQ_MASK_OFS: begin
          if (avs_byteenable_in[0]) begin
            next_irq_mask = avs_writedata_in[IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Set wins over clear
    next_irq_status = (irq_status & ~irq_clear) | irq_event;
    next_irq = |(next_irq_status & next_irq_mask);

    // One wait cycle per access
    next_waitrequest = !((avs_read_in || avs_write_in) && avs_waitrequest_out);
    next_readdata = avs_readdata_out;
    if (avs_read_in && avs_waitrequest_out) begin
      next_readdata = reg_read(avs_address_in, cfg, rx_if.level, tx_free, irq_status,
        irq_mask);
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cfg <= FIFO_CFG_RESET;
      irq_status <= '0;
      irq_mask <= '0;
      avs_readdata_out <= 32'h0000_0000;
      avs_waitrequest_out <= 1'b1;
      rx_word_out <= '0;
      rx_word_valid_out <= 1'b0;
      rx_word_avail_out <= 1'b0;
      tx_word_room_out <= 1'b1;
      rx_byte_ready_out <= 1'b1;
      tx_byte_valid_out <= 1'b0;
      tx_byte_out <= 8'h00;
      rx_level_flag_out <= 1'b0;
      tx_space_flag_out <= 1'b1;
      irq_out <= 1'b0;
    end else begin
      cfg <= next_cfg;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      avs_readdata_out <= next_readdata;
      avs_waitrequest_out <= next_waitrequest;
      rx_word_out <= next_rx_word;
      rx_word_valid_out <= next_rx_word_valid;
      rx_word_avail_out <= next_rx_avail;
      tx_word_room_out <= next_tx_room;
      rx_byte_ready_out <= next_rx_ready;
      tx_byte_valid_out <= next_tx_valid;
      tx_byte_out <= next_tx_byte;
      rx_level_flag_out <= next_rx_flag;
      tx_space_flag_out <= next_tx_flag;
      irq_out <= next_irq;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_status_write;
    avs_write_in && !avs_waitrequest_out && avs_address_in == FIFO_STATUS_OFS
      && avs_byteenable_in[3];
  endsequence
  sequence s_status_read;
    avs_read_in && avs_waitrequest_out && avs_address_in == FIFO_STATUS_OFS;
  endsequence

  property p_rx_width16;
    rx_if.pop && cfg[RX_SIZE_LSB +: 2] == SIZE_16 |=>
      rx_word_valid_out && rx_word_out[63:16] == 48'h0;
  endproperty
  a_rx_width16: assert property (p_rx_width16)
    else $error("16-bit receive read wrong");

  property p_rx_width32;
    rx_if.pop && !rx_if.push && !rx_if.flush && cfg[RX_SIZE_LSB +: 2] == SIZE_32 |=>
      rx_if.level == $past(rx_if.level) - 8'h04;
  endproperty
  a_rx_width32: assert property (p_rx_width32)
    else $error("32-bit receive read did not take 4 bytes");

  property p_tx_width64;
    tx_if.push && !tx_if.pop && cfg[TX_SIZE_LSB +: 2] == SIZE_64 |=>
      tx_if.level == $past(tx_if.level) + 8'h08;
  endproperty
  a_tx_width64: assert property (p_tx_width64)
    else $error("64-bit transmit write did not add 8 bytes");

  property p_tx_unpack;
    tx_if.pop |=> tx_byte_valid_out && tx_byte_out == $past(tx_if.pop_data[7:0]);
  endproperty
  a_tx_unpack: assert property (p_tx_unpack)
    else $error("transmit byte not presented");

  property p_rx_flag;
    $stable(cfg) |-> rx_level_flag_out == (rx_if.level > cfg[RX_THR_LSB +: 8])
      && (!$rose(rx_level_flag_out) || irq_status[IRQ_RX_LEVEL]);
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("receive level flag wrong");

  property p_tx_flag;
    $rose(tx_space_flag_out) && $stable(cfg) && $past(cfg) == $past(cfg, 2)
      && !$past(tx_if.flush) |->
      tx_free == cfg[TX_THR_LSB +: 8] && irq_status[IRQ_TX_SPACE];
  endproperty
  a_tx_flag: assert property (p_tx_flag)
    else $error("transmit space flag wrong");

  property p_rx_flush;
    s_status_write ##0 avs_writedata_in[RX_FLUSH_BIT] |=> rx_if.level == 8'h00;
  endproperty
  a_rx_flush: assert property (p_rx_flush)
    else $error("receive flush failed");

  property p_tx_flush;
    s_status_write ##0 avs_writedata_in[TX_FLUSH_BIT] |=> tx_free == 8'h80 && !tx_byte_valid_out;
  endproperty
  a_tx_flush: assert property (p_tx_flush)
    else $error("transmit flush failed");

  property p_status_read;
    s_status_read |=> !avs_waitrequest_out && avs_readdata_out[15:8] == $past(rx_if.level)
      && avs_readdata_out[7:0] == $past(tx_free) && avs_readdata_out[31:16] == 16'h0;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read wrong");
endmodule // nand_async_fifo_thresholds

// File: nand_async_fifo_thresholds_tb_top.sv
// Self-checking testbench of the NAND data FIFO block
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
`define WAITC(c) begin k = 0; while (!(c)) begin @(posedge ref_clk_in); k++; \
  if (k > 2000) begin num_errors++; tally_and_finish(); end end end
module nand_async_fifo_thresholds_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nand_fifo_pkg::*;
  logic ref_clk_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [ADDR_W-1:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic [3:0] avs_byteenable_in;
  logic rx_byte_valid_in, rx_byte_ready_out, tx_byte_valid_out, tx_byte_ready_in;
  logic [7:0] rx_byte_in, tx_byte_out, b;
  logic rx_word_rd_in, rx_word_valid_out, rx_word_avail_out, tx_word_wr_in;
  logic [63:0] rx_word_out, tx_word_in, exp_w;
  logic tx_word_room_out, rx_level_flag_out, tx_space_flag_out, irq_out, sink_en;
  logic [15:0] rx_todo;
  int num_errors, checks_done, seed, k, w, n;

  nand_async_fifo_thresholds u_nand_async_fifo_thresholds (.ref_clk_in, .rst_n_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
    .avs_readdata_out, .avs_waitrequest_out, .rx_byte_valid_in, .rx_byte_in,
    .rx_byte_ready_out, .tx_byte_valid_out, .tx_byte_out, .tx_byte_ready_in, .rx_word_rd_in,
    .rx_word_out, .rx_word_valid_out, .rx_word_avail_out, .tx_word_wr_in, .tx_word_in,
    .tx_word_room_out, .rx_level_flag_out, .tx_space_flag_out, .irq_out);
  flash_side_model u_flash_side_model (.clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .rx_todo_in(rx_todo), .sink_en_in(sink_en), .rx_byte_ready_in(rx_byte_ready_out),
    .rx_byte_valid_out(rx_byte_valid_in), .rx_byte_out(rx_byte_in),
    .tx_byte_valid_in(tx_byte_valid_out), .tx_byte_in(tx_byte_out),
    .tx_byte_ready_out(tx_byte_ready_in));

  // ==========================================================
  // Clock and tasks
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task tally_and_finish;
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task cyc(input int c);
    repeat (c) @(posedge ref_clk_in);
  endtask
  // Avalon access held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    k = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    do begin
      @(posedge ref_clk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 50);
    if (avs_waitrequest_out !== 1'b0) begin
      num_errors++;
      tally_and_finish();
    end
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task tx_word;
    exp_w = {$random(seed), $random(seed)};
    tx_word_in <= exp_w;
    tx_word_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    tx_word_wr_in <= 1'b0;
  endtask
  task flush_all;
    bus(1'b1, FIFO_STATUS_OFS, 32'hc000_0000);
    u_flash_side_model.sent_q.delete();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = '0;
    avs_writedata_in = '0;
    avs_byteenable_in = 4'hf;
    rx_word_rd_in = 1'b0;
    tx_word_wr_in = 1'b0;
    tx_word_in = '0;
    rx_todo = 16'h0;
    sink_en = 1'b0;
    num_errors = 0;
    checks_done = 0;
    seed = 29212;
    cyc(2);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    `CHK(irq_out, 1'b0)
    `CHK(tx_word_room_out, 1'b1)
    `CHK(rx_word_avail_out, 1'b0)
    `CHK(tx_space_flag_out, 1'b1)
    bus(1'b0, FIFO_CFG_OFS, '0);
    `CHK(rd, 32'h0028_4040)
    bus(1'b0, FIFO_STATUS_OFS, '0);
    `CHK(rd, 32'h0000_0080)
    bus(1'b0, 8'h68, '0);
    `CHK(rd, 32'h0)
    // Only the enabled byte lane is written
    avs_byteenable_in <= 4'h1;
    bus(1'b1, FIFO_CFG_OFS, 32'hffff_ffff);
    avs_byteenable_in <= 4'hf;
    bus(1'b0, FIFO_CFG_OFS, '0);
    `CHK(rd, 32'h0028_40ff)
    `CHK(tx_space_flag_out, 1'b0)
    bus(1'b1, IRQ_MASK_OFS, 32'h3);
    // Every width code on both FIFOs
    for (w = 0; w < 4; w++) begin
      n = 1 << w;
      bus(1'b1, FIFO_CFG_OFS, {10'h0, w[1:0], w[1:0], 2'b00, 8'hff, 8'h00});
      flush_all();
      rx_todo <= rx_todo + 16'(n + 1);
      `WAITC(u_flash_side_model.sent_q.size() == n + 1)
      cyc(2);
      bus(1'b0, FIFO_STATUS_OFS, '0);
      `CHK(rd, {16'h0, 8'(n + 1), 8'h80})
      `CHK(rx_word_avail_out, 1'b1)
      rx_word_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rx_word_rd_in <= 1'b0;
      @(posedge ref_clk_in);
      exp_w = '0;
      for (k = 0; k < n; k++) exp_w[8*k +: 8] = u_flash_side_model.sent_q.pop_front();
      `CHK(rx_word_valid_out, 1'b1)
      `CHK(rx_word_out, exp_w)
      tx_word();
      sink_en <= 1'b1;
      `WAITC(u_flash_side_model.got_q.size() == n)
      for (k = 0; k < n; k++) begin
        b = u_flash_side_model.got_q.pop_front();
        `CHK(b, exp_w[8*k +: 8])
      end
      sink_en <= 1'b0;
      cyc(3);
      bus(1'b0, FIFO_STATUS_OFS, '0);
      `CHK(rd, 32'h0000_0180)
      `CHK(rx_word_avail_out, n == 1)
    end
    // Receive level threshold and interrupt
    bus(1'b1, FIFO_CFG_OFS, 32'h0000_037f);
    flush_all();
    bus(1'b1, IRQ_STATUS_OFS, 32'h3);
    rx_todo <= rx_todo + 16'd3;
    `WAITC(u_flash_side_model.sent_q.size() == 3)
    cyc(3);
    `CHK(rx_level_flag_out, 1'b0)
    rx_todo <= rx_todo + 16'd1;
    `WAITC(u_flash_side_model.sent_q.size() == 4)
    cyc(3);
    `CHK(rx_level_flag_out, 1'b1)
    `CHK(irq_out, 1'b1)
    bus(1'b0, IRQ_STATUS_OFS, '0);
    `CHK(rd, 32'h1)
    bus(1'b1, IRQ_MASK_OFS, 32'h2);
    cyc(1);
    `CHK(irq_out, 1'b0)
    bus(1'b1, IRQ_STATUS_OFS, 32'h1);
    bus(1'b0, IRQ_STATUS_OFS, '0);
    `CHK(rd, 32'h0)
    // Transmit space threshold on drain
    bus(1'b1, FIFO_CFG_OFS, 32'h000c_037f);
    bus(1'b1, FIFO_STATUS_OFS, 32'h4000_0000);
    tx_word();
    cyc(3);
    `CHK(tx_space_flag_out, 1'b0)
    sink_en <= 1'b1;
    `WAITC(u_flash_side_model.got_q.size() == 8)
    cyc(3);
    `CHK(tx_space_flag_out, 1'b1)
    `CHK(irq_out, 1'b1)
    bus(1'b0, IRQ_STATUS_OFS, '0);
    `CHK(rd, 32'h2)
    bus(1'b1, IRQ_STATUS_OFS, 32'h2);
    cyc(1);
    `CHK(irq_out, 1'b0)
    // Fill transmit with the sink stalled until no word fits
    sink_en <= 1'b0;
    cyc(1);
    tx_word_wr_in <= 1'b1;
    repeat (16) begin
      tx_word_in <= {$random(seed), $random(seed)};
      @(posedge ref_clk_in);
    end
    tx_word_wr_in <= 1'b0;
    cyc(2);
    `CHK(tx_word_room_out, 1'b0)
    `CHK(tx_space_flag_out, 1'b0)
    bus(1'b0, FIFO_STATUS_OFS, '0);
    `CHK(rd, 32'h0000_0401)
    tally_and_finish();
  end
endmodule // nand_async_fifo_thresholds_tb_top

// File: nand_fifo_pkg.sv
// Shared constants, types and helpers for the NAND data FIFO block
package nand_fifo_pkg;
  localparam int FIFO_DEPTH = 128;
  localparam int PTR_W = 7;
  localparam int LEVEL_W = 8;
  localparam int WORD_BYTES = 8;
  localparam int WORD_BITS = 64;
  localparam int ADDR_W = 8;
  localparam int IRQ_W = 2;
  localparam logic [7:0] FIFO_STATUS_OFS = 8'h60;
  localparam logic [7:0] FIFO_CFG_OFS = 8'h64;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h90;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h94;
  localparam int RX_FLUSH_BIT = 31;
  localparam int TX_FLUSH_BIT = 30;
  localparam int RX_SIZE_LSB = 20;
  localparam int TX_SIZE_LSB = 18;
  localparam int RX_THR_LSB = 8;
  localparam int TX_THR_LSB = 0;
  localparam int IRQ_RX_LEVEL = 0;
  localparam int IRQ_TX_SPACE = 1;
  localparam logic [31:0] FIFO_CFG_RESET = 32'h0028_4040;
  localparam logic [31:0] FIFO_CFG_MASK = 32'h003c_ffff;

  typedef enum logic [1:0] {SIZE_8, SIZE_16, SIZE_32, SIZE_64} fifo_size_t;

  // Bytes moved per internal-side access for a width code
  function automatic logic [3:0] size_bytes(input logic [1:0] code);
    return 4'h1 << code;
  endfunction
endpackage
